/* File: cpmm_checker.sv */
/* Assertions on cpmm_top ports. Assumes the bind below. */
`timescale 1ns/1ns
module cpmm_checker
(
    input wire        clk_in,
    input wire        rst_in,
    input wire        mode_write_op_in,
    input wire [15:0] mode_src_in,
    input wire        operand_issue_op_in,
    input wire        result_preload_op_in,
    input wire [15:0] opnd_hi_in,
    input wire [15:0] opnd_lo_in,
    input wire        res_valid_out,
    input wire [3:0]  res_flags_out,
    input wire [31:0] result_reg_zero_out,
    input wire [6:0]  coprocessor_mode_select_out
);
    wire [3:0]  op = coprocessor_mode_select_out[3:0];
    wire        ld = operand_issue_op_in | result_preload_op_in;
    wire [31:0] r0 = result_reg_zero_out;
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    property p_v; operand_issue_op_in |=> res_valid_out; endproperty
    a_v: assert property (p_v) else $error("late");
    property p_f; res_valid_out |-> res_flags_out == 4'h0; endproperty
    a_f: assert property (p_f) else $error("flags");
    property p_m; mode_write_op_in |=> coprocessor_mode_select_out == $past(mode_src_in[6:0]); endproperty
    a_m: assert property (p_m) else $error("mode");
    property p_c; ld && op == 4'h0 |=> r0 == 32'h0; endproperty
    a_c: assert property (p_c) else $error("clear");
    property p_l; ld && op == 4'h2 |=> r0 == $past({opnd_hi_in, opnd_lo_in}); endproperty
    a_l: assert property (p_l) else $error("load");
    property p_u; operand_issue_op_in && op == 4'h4 |=> r0 == $past(opnd_hi_in) * $past(opnd_lo_in); endproperty
    a_u: assert property (p_u) else $error("product");
    property p_r; operand_issue_op_in && op == 4'h3 |=> $stable(r0); endproperty
    a_r: assert property (p_r) else $error("read");
    property p_x; ld && op > 4'hA |=> $stable(r0); endproperty
    a_x: assert property (p_x) else $error("reserved");
endmodule
bind cpmm_top cpmm_checker u_chk (.*);

/* File: cpmm_host.sv */
/* Host core model. Assumes the shared clk_in. */
`timescale 1ns/1ns
module cpmm_host
(
    input  wire        clk_in,
    output reg  [2:0]  op_out = 0,
    output reg  [15:0] hi_out = 0,
    output reg  [15:0] lo_out = 0
);
    // One strobe per call: 1 mode write, 2 issue, 4 load only
    task op(input [2:0] k, input [15:0] h, input [15:0] l);
        @(posedge clk_in);
        op_out <= k;
        hi_out <= h;
        lo_out <= l;
        @(posedge clk_in);
        op_out <= 3'h0;
        hi_out <= ~h;
        lo_out <= ~l;
    endtask
endmodule

/* File: cpmm_mult.v */
/*
 * Single-cycle 16x16 multiplier, signed or unsigned.
 * Assumes operands are stable in the cycle they are used.
 */
`timescale 1ns/1ns
module cpmm_mult
(
    input  wire [15:0] a_in,
    input  wire [15:0] b_in,
    input  wire        signed_in,
    output wire [31:0] prod_out
);

wire [32:0] a_ext;
wire [32:0] b_ext;
wire [65:0] prod_full;

assign a_ext     = {{17{signed_in & a_in[15]}}, a_in};
assign b_ext     = {{17{signed_in & b_in[15]}}, b_in};
assign prod_full = a_ext * b_ext;
assign prod_out  = prod_full[31:0];

endmodule

/* File: cpmm_regs.vh */
/*
 * Constants for the coprocessor mode front end and multiply datapath.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef CPMM_REGS_VH
`define CPMM_REGS_VH

`define CPMM_MODE_W        7
`define CPMM_OUT_LSB       4
`define CPMM_OUT_MSB       6
`define CPMM_OP_LSB        0
`define CPMM_OP_MSB        3
`define CPMM_MODE_RST      7'h00

`define CPMM_OUT_R0_LO     3'h0
`define CPMM_OUT_R0_HI     3'h1
`define CPMM_OUT_R1_LO     3'h2
`define CPMM_OUT_R1_HI     3'h3

`define CPMM_OP_INIT0      4'h0
`define CPMM_OP_INIT1      4'h1
`define CPMM_OP_INIT2      4'h2
`define CPMM_OP_READ       4'h3
`define CPMM_OP_MULU       4'h4
`define CPMM_OP_MULS       4'h5
`define CPMM_OP_MACU       4'h6
`define CPMM_OP_MACS       4'h7
`define CPMM_OP_DIVU       4'h8
`define CPMM_OP_DIVS       4'h9
`define CPMM_OP_INIT3      4'hA

`define CPMM_RES_RST       32'h0000_0000
`define CPMM_FLAGS_CLR     4'h0
`define CPMM_HALF_LO       15:0
`define CPMM_HALF_HI       31:16

`endif

/* File: cpmm_top.v */
/*
 * Coprocessor mode control and multiply datapath.
 * Assumes the host core shares clk_in/rst_in and presents one-cycle strobes.
 */
// Overview of operation
// - Mode write latches source bits six to zero
// - Mode bits six-four pick returned half
// - Code zero clears both result registers
// - Code one loads addend into low half
// - Codes two, ten load full registers
// - Code three reads without modifying registers
// - Codes four, five multiply unsigned, signed
// - Codes six, seven select multiply-accumulate
// - Codes eight, nine select division
// - Multiply stores full product in register zero
// - Operand issue returns selected half one cycle later
// - Multiply returns all four flags cleared
// - Register zero holds until overwritten
// - Multiply and accumulate finish in one cycle
`timescale 1ns/1ns
`include "cpmm_regs.vh"
module cpmm_top
(
    input  wire        clk_in,
    input  wire        rst_in,
    input  wire        mode_write_op_in,
    input  wire [15:0] mode_src_in,
    input  wire        operand_issue_op_in,
    input  wire        result_preload_op_in,
    input  wire [15:0] opnd_hi_in,
    input  wire [15:0] opnd_lo_in,
    output wire        ext_op_out,
    output wire        res_valid_out,
    output reg  [15:0] res_data_out,
    output reg  [3:0]  res_flags_out,
    output reg         mac_ovf_out,
    output wire [31:0] result_reg_zero_out,
    output wire [31:0] result_reg_one_out,
    output wire [6:0]  coprocessor_mode_select_out
);

////////////////////////////////////////////////////////////////////////////
// Mode register

reg  [`CPMM_MODE_W-1:0] coprocessor_mode_select_r;
reg  [31:0]             result_reg_zero_r;
reg  [31:0]             result_reg_one_r;
reg                     res_valid_r;
wire [3:0]              op_code;
wire [2:0]              out_sel;

assign op_code = coprocessor_mode_select_r[`CPMM_OP_MSB:`CPMM_OP_LSB];
assign out_sel = coprocessor_mode_select_r[`CPMM_OUT_MSB:`CPMM_OUT_LSB];
assign coprocessor_mode_select_out = coprocessor_mode_select_r;
assign result_reg_zero_out = result_reg_zero_r;
assign result_reg_one_out  = result_reg_one_r;
assign res_valid_out = res_valid_r;
// Division ops are handed to the external divide unit
assign ext_op_out = (op_code == `CPMM_OP_DIVU) || (op_code == `CPMM_OP_DIVS);

always @(posedge clk_in or posedge rst_in)
begin
    if (rst_in)
        coprocessor_mode_select_r <= `CPMM_MODE_RST;
    else if (mode_write_op_in)
        coprocessor_mode_select_r <= mode_src_in[`CPMM_MODE_W-1:0];
end

////////////////////////////////////////////////////////////////////////////
// Multiply and accumulate datapath

wire        is_signed;
wire [31:0] product;
wire [32:0] mac_sum;
wire        mac_ovf_nxt;

assign is_signed = (op_code == `CPMM_OP_MULS) || (op_code == `CPMM_OP_MACS);

cpmm_mult u_mult
(
    .a_in      (opnd_hi_in),
    .b_in      (opnd_lo_in),
    .signed_in (is_signed),
    .prod_out  (product)
);

assign mac_sum = {1'b0, result_reg_zero_r} + {1'b0, product};
assign mac_ovf_nxt = is_signed ?
    ((result_reg_zero_r[31] == product[31]) && (mac_sum[31] != product[31])) :
    mac_sum[32];

////////////////////////////////////////////////////////////////////////////
// Result registers

reg [31:0] result_reg_zero_nxt;
reg [31:0] result_reg_one_nxt;
reg        ovf_nxt;

always @*
begin
    result_reg_zero_nxt = result_reg_zero_r;
    result_reg_one_nxt = result_reg_one_r;
    ovf_nxt  = mac_ovf_out;
    if (operand_issue_op_in || result_preload_op_in)
    begin
        case (op_code)
            `CPMM_OP_INIT0:
            begin
                result_reg_zero_nxt = `CPMM_RES_RST;
                result_reg_one_nxt = `CPMM_RES_RST;
            end
            `CPMM_OP_INIT1:
                result_reg_zero_nxt[`CPMM_HALF_LO] = opnd_lo_in;
            `CPMM_OP_INIT2:
                result_reg_zero_nxt = {opnd_hi_in, opnd_lo_in};
            `CPMM_OP_INIT3:
                result_reg_one_nxt = {opnd_hi_in, opnd_lo_in};
            `CPMM_OP_MULU, `CPMM_OP_MULS:
                if (operand_issue_op_in)
                    result_reg_zero_nxt = product;
            `CPMM_OP_MACU, `CPMM_OP_MACS:
                if (operand_issue_op_in)
                begin
                    result_reg_zero_nxt = mac_sum[31:0];
                    ovf_nxt  = mac_ovf_nxt;
                end
            default:
                result_reg_zero_nxt = result_reg_zero_r;
        endcase
    end
end

always @(posedge clk_in or posedge rst_in)
begin
    if (rst_in)
    begin
        result_reg_zero_r <= `CPMM_RES_RST;
        result_reg_one_r  <= `CPMM_RES_RST;
        mac_ovf_out       <= 1'b0;
    end
    else
    begin
        result_reg_zero_r <= result_reg_zero_nxt;
        result_reg_one_r  <= result_reg_one_nxt;
        mac_ovf_out       <= ovf_nxt;
    end
end

////////////////////////////////////////////////////////////////////////////
// Returned half, one cycle after the issue

function [15:0] cpmm_pick;
    input [2:0]  sel;
    input [31:0] r0;
    input [31:0] r1;
    begin
        case (sel)
            `CPMM_OUT_R0_LO: cpmm_pick = r0[`CPMM_HALF_LO];
            `CPMM_OUT_R0_HI: cpmm_pick = r0[`CPMM_HALF_HI];
            `CPMM_OUT_R1_LO: cpmm_pick = r1[`CPMM_HALF_LO];
            `CPMM_OUT_R1_HI: cpmm_pick = r1[`CPMM_HALF_HI];
            default:         cpmm_pick = 16'h0000;
        endcase
    end
endfunction

always @(posedge clk_in or posedge rst_in)
begin
    if (rst_in)
    begin
        res_valid_r   <= 1'b0;
        res_data_out  <= 16'h0000;
        res_flags_out <= `CPMM_FLAGS_CLR;
    end
    else
    begin
        res_valid_r <= operand_issue_op_in;
        if (operand_issue_op_in)
        begin
            res_data_out  <= cpmm_pick(out_sel, result_reg_zero_nxt, result_reg_one_nxt);
            res_flags_out <= `CPMM_FLAGS_CLR;
        end
    end
end

endmodule

/* File: testbench.sv */
/* Bench for cpmm_top. Assumes cpmm_host drives the core side. */
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; $display("unexpected %0t value", $time); end end
module testbench;
    reg         clk_in = 0;
    reg         rst_in = 1;
    wire [2:0]  s;
    wire        ext, v, ovf;
    wire [15:0] hi, lo, d;
    wire [3:0]  f;
    wire [31:0] r0, r1;
    wire [6:0]  md;
    integer     n_errors = 0, n_compared = 0, cyc = 0, i;
    reg  [55:0] t [12] = '{56'h04_0003_0005_000F, 56'h15_FFFF_0002_FFFF, 56'h02_1234_5678_5678,
        56'h13_0000_0000_1234, 56'h3A_ABCD_0123_ABCD, 56'h23_0000_0000_0123, 56'h01_0000_0077_0077,
        56'h06_0002_0003_007D, 56'h07_FFFF_0001_007C, 56'h0B_0009_0009_007C, 56'h09_0009_0009_007C,
        56'h00_0000_0000_0000};
    always #10 clk_in = ~clk_in;
    cpmm_host u_host (.clk_in(clk_in), .op_out(s), .hi_out(hi), .lo_out(lo));
    cpmm_top u_dut (.clk_in(clk_in), .rst_in(rst_in), .mode_write_op_in(s[0]), .mode_src_in(lo),
        .operand_issue_op_in(s[1]), .result_preload_op_in(s[2]), .opnd_hi_in(hi), .opnd_lo_in(lo),
        .ext_op_out(ext), .res_valid_out(v), .res_data_out(d), .res_flags_out(f), .mac_ovf_out(ovf),
        .result_reg_zero_out(r0), .result_reg_one_out(r1), .coprocessor_mode_select_out(md));
    task tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            n_errors++;
            tally_and_finish;
        end
    end
    initial
    begin
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        for (i = 0; i < 12; i++)
        begin
            u_host.op(1, 0, {8'h00, t[i][55:48]});
            u_host.op(2, t[i][47:32], t[i][31:16]);
            #1 `CHK(d, t[i][15:0])
            `CHK(f, 4'h0)
            `CHK(v, 1'b1)
            $display("row %0d done", i);
        end
        `CHK(r1, 32'h0)
        u_host.op(1, 0, 16'h0002);
        u_host.op(4, 16'hBEEF, 16'h0042);
        #1 `CHK(r0, 32'hBEEF0042)
        `CHK(v, 1'b0)
        u_host.op(1, 0, 16'h0002);
        u_host.op(4, 16'hFFFF, 16'hFFFF);
        u_host.op(1, 0, 16'h0006);
        u_host.op(2, 16'h0002, 16'h8000);
        #1 `CHK(ovf, 1'b1)
        `CHK(d, 16'hFFFF)
        $display("mac carry done");
        u_host.op(1, 0, 16'h0008);
        #1 `CHK(ext, 1'b1)
        @(posedge clk_in) rst_in <= 1'b1;
        @(posedge clk_in) #1 `CHK(md, 7'h00)
        `CHK(r0, 32'h0)
        @(posedge clk_in) rst_in <= 1'b0;
        $display("tail done");
        tally_and_finish;
    end
endmodule
